// file: csr_defines.svh
/*
 Offsets, field positions, reset values and fixed figures of the core special register file.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// Byte offsets of the APB register window
`define CSR_OFF_STACK_TOP_UPPER        12'h000
`define CSR_OFF_STACK_TOP_HIGH        12'h004
`define CSR_OFF_STACK_TOP_LOW        12'h008
`define CSR_OFF_STK         12'h00c
`define CSR_OFF_PC_LATCH_UPPER      12'h010
`define CSR_OFF_PC_LATCH_HIGH      12'h014
`define CSR_OFF_PCL         12'h018
`define CSR_OFF_TBLU        12'h01c
`define CSR_OFF_TBLH        12'h020
`define CSR_OFF_TBLL        12'h024
`define CSR_OFF_TABLE_READ_LATCH      12'h028
`define CSR_OFF_MULTIPLY_RESULT_HIGH       12'h02c
`define CSR_OFF_MULTIPLY_RESULT_LOW       12'h030
`define CSR_OFF_IRQ1        12'h034
`define CSR_OFF_IRQ2        12'h038
`define CSR_OFF_IRQ3        12'h03c
`define CSR_OFF_PTR0H       12'h040
`define CSR_OFF_PTR0L       12'h044
`define CSR_OFF_WORKING_ACCUMULATOR        12'h048
`define CSR_OFF_PTR1H       12'h04c
`define CSR_OFF_PTR1L       12'h050
`define CSR_OFF_IND_PLAIN   12'h054
`define CSR_OFF_IND_POSTINC 12'h058
`define CSR_OFF_IND_POSTDEC 12'h05c
`define CSR_OFF_IND_PREINC  12'h060
`define CSR_OFF_IND_OFFSET  12'h064
`define CSR_OFF_SER_ADDR    12'h068
`define CSR_OFF_SER_CTL2    12'h06c
`define CSR_OFF_PAR_HIGH    12'h070
`define CSR_OFF_PAR_LOW     12'h074
`define CSR_OFF_PAR_MODE    12'h078
`define CSR_OFF_PORTA_DIR   12'h07c
`define CSR_OFF_OSC_STAT    12'h080
`define CSR_OFF_IRQ_STAT    12'h084
`define CSR_OFF_IRQ_MASK    12'h088

// Field positions and codes
`define CSR_SER_MASK_CODE   4'h9
`define CSR_OSC_STARTUP_STATUS_BIT        3
`define CSR_PC_LATCH_UPPER_B21      5
`define CSR_STK_FULL_BIT    7
`define CSR_STK_UNF_BIT     6

// Reset values
`define CSR_RST_ZERO        8'h00
`define CSR_RST_IRQ2        8'hff
`define CSR_RST_IRQ3        8'hc0
`define CSR_RST_DIR         8'hff
`define CSR_RST_SER_ADDR    8'h00
`define CSR_RST_SER_MASK    8'hff

// Implemented-bit masks
`define CSR_MASK_TOS_U      8'h1f
`define CSR_MASK_STK        8'hdf
`define CSR_MASK_PTR_H      8'h0f
`define CSR_MASK_TBL_U      8'h3f
`define CSR_MASK_IRQ_EV     3'h7

`endif

// file: csr_pkg.sv
/*
 Types of the core special register file.
 Assumes csr_defines.svh holds all numeric constants.
*/
package csr_pkg;
    // Data memory request toward the indirect-access path
    typedef struct packed {
        logic        req;
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } csr_dmem_req_t;

    // Pointer update kind for an indirect access
    typedef enum logic [4:0] {
        CSR_IND_NONE    = 5'b00001,
        CSR_IND_PLAIN   = 5'b00010,
        CSR_IND_POSTINC = 5'b00100,
        CSR_IND_POSTDEC = 5'b01000,
        CSR_IND_PREINC  = 5'b10000
    } csr_ind_kind_t;

    // APB access phase state
    typedef enum logic [2:0] {
        CSR_ST_IDLE = 3'b001,
        CSR_ST_MEM  = 3'b010,
        CSR_ST_DONE = 3'b100
    } csr_state_t;
endpackage : csr_pkg

// file: csr_core_regs.sv
/*
 Core special register file behind an APB slave: stack, PC latch, table pointer, product,
 working, interrupt control, two indirect pointers with their virtual access registers,
 mode-shared serial address/mask and parallel address/output registers, event interrupt.
 Assumes a data memory answering in the same cycle as dmem_o.req, and mode inputs in the same clock domain
 except the oscillator, package and two-speed straps, which are synchronised here.
*/
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "csr_defines.svh"

module csr_core_regs
(
    input  wire logic                   clock_i,
    input  wire logic                   rstn_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    output csr_pkg::csr_dmem_req_t      dmem_o,
    input  wire logic [7:0]             dmem_rdata_i,
    input  wire logic                   par_master_i,
    input  wire logic                   ser_twowire_slave_i,
    input  wire logic                   serial_prog_i,
    input  wire logic                   two_speed_i,
    input  wire logic                   osc_on_porta_i,
    input  wire logic                   large_pkg_i,
    input  wire logic [2:0]             event_i,
    output logic                        irq_o,
    output logic [7:0]                  par_addr_high_o,
    output logic [7:0]                  par_addr_low_o
);
    csr_pkg::csr_state_t    state_q;
    csr_pkg::csr_ind_kind_t kind_q;
    logic [7:0]  stack_top_upper_q, stack_top_high_q, stack_top_low_q, stk_q, pc_latch_upper_q, pc_latch_high_q, pcl_q;
    logic [7:0]  tblu_q, tblh_q, tbll_q, table_read_latch_q, multiply_result_high_q, multiply_result_low_q;
    logic [7:0]  irq1_q, irq2_q, irq3_q, working_accumulator_q, ser_addr_q, ser_mask_q, ser_ctl2_q;
    logic [7:0]  par_h_q, par_l_q, dir_q, ist_q, imask_q;
    logic [11:0] ptr0_q, ptr1_q, ptr_sel, ptr_new;
    logic        osc_startup_status_q, ptr_sel1_q;
    logic [1:0]  osc_s_q, pkg_s_q, two_s_q;
    logic        rst_seen_q;
    logic        setup, wr, rd, ind_hit, ind_sel1;
    logic [11:0] off;
    logic [7:0]  wb, rbyte;
    logic        mapped;

    // Byte of a word and the offset within the window
    assign off   = paddr_i;
    assign wb    = pwdata_i[7:0];
    assign setup = psel_i && !penable_i;
    assign wr    = psel_i && penable_i && pwrite_i && state_q == csr_pkg::CSR_ST_DONE;
    assign rd    = psel_i && penable_i && !pwrite_i && state_q == csr_pkg::CSR_ST_DONE;

    // Indirect access decode
    assign ind_sel1 = (off == `CSR_OFF_IND_POSTDEC) || (off == `CSR_OFF_IND_PREINC);
    assign ind_hit  = (off == `CSR_OFF_IND_PLAIN) || (off == `CSR_OFF_IND_POSTINC) ||
                      ind_sel1 || (off == `CSR_OFF_IND_OFFSET);
    assign ptr_sel  = ind_sel1 ? ptr1_q : ptr0_q;

    // Pointer step by one, up or down, wrapping at the 12-bit field
    function automatic logic [11:0] csr_step(input logic [11:0] p, input logic up);
        csr_step = up ? p + 12'h001 : p - 12'h001;
    endfunction : csr_step

    // Data memory address for the decoded access
    always_comb
    begin
        ptr_new = ptr_sel;
        if (off == `CSR_OFF_IND_PREINC)
            ptr_new = csr_step(ptr_sel, 1'b1);
        else if (off == `CSR_OFF_IND_OFFSET)
            ptr_new = ptr_sel + {4'h0, working_accumulator_q};
    end

    // Two-flop synchronisers for straps, running through reset so they are settled at release
    always_ff @(posedge clock_i)
    begin
        osc_s_q <= {osc_s_q[0], osc_on_porta_i};
        pkg_s_q <= {pkg_s_q[0], large_pkg_i};
        two_s_q <= {two_s_q[0], two_speed_i};
    end

    // Access sequencer: indirect accesses wait one cycle for data memory
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= csr_pkg::CSR_ST_IDLE;
            kind_q     <= csr_pkg::CSR_IND_NONE;
            ptr_sel1_q <= 1'b0;
            dmem_o     <= '0;
            pready_o   <= 1'b0;
        end
        else
        begin
            dmem_o.req <= 1'b0;
            pready_o   <= 1'b0;
            case (state_q)
                csr_pkg::CSR_ST_IDLE:
                begin
                    if (setup && ind_hit)
                    begin
                        dmem_o.req   <= 1'b1;
                        dmem_o.we    <= pwrite_i;
                        dmem_o.addr  <= ptr_new;
                        dmem_o.wdata <= wb;
                        ptr_sel1_q   <= ind_sel1;
                        state_q      <= csr_pkg::CSR_ST_MEM;
                    end
                    else if (setup)
                    begin
                        pready_o <= 1'b1;
                        state_q  <= csr_pkg::CSR_ST_DONE;
                    end
                end
                csr_pkg::CSR_ST_MEM:
                begin
                    pready_o <= 1'b1;
                    state_q  <= csr_pkg::CSR_ST_DONE;
                end
                csr_pkg::CSR_ST_DONE:
                    state_q <= csr_pkg::CSR_ST_IDLE;
                default:
                    state_q <= csr_pkg::CSR_ST_IDLE;
            endcase
        end
    end

    // Pointers: software writes and access side effects
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ptr0_q <= 12'h000;
            ptr1_q <= 12'h000;
        end
        else if (wr || rd)
        begin
            // Pointer bytes change on writes only; indirect side effects on both directions
            case (off)
                `CSR_OFF_PTR0H: if (wr) ptr0_q[11:8] <= wb[3:0];
                `CSR_OFF_PTR0L: if (wr) ptr0_q[7:0]  <= wb;
                `CSR_OFF_PTR1H: if (wr) ptr1_q[11:8] <= wb[3:0];
                `CSR_OFF_PTR1L: if (wr) ptr1_q[7:0]  <= wb;
                `CSR_OFF_IND_POSTINC: ptr0_q <= csr_step(ptr0_q, 1'b1);
                `CSR_OFF_IND_POSTDEC: ptr1_q <= csr_step(ptr1_q, 1'b0);
                `CSR_OFF_IND_PREINC:  ptr1_q <= csr_step(ptr1_q, 1'b1);
                default: ;
            endcase
        end
    end

    // Core registers written by software
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            stack_top_upper_q <= `CSR_RST_ZERO; stack_top_high_q <= `CSR_RST_ZERO; stack_top_low_q <= `CSR_RST_ZERO;
            stk_q <= `CSR_RST_ZERO; pc_latch_upper_q <= `CSR_RST_ZERO; pc_latch_high_q <= `CSR_RST_ZERO;
            pcl_q <= `CSR_RST_ZERO; tblu_q <= `CSR_RST_ZERO; tblh_q <= `CSR_RST_ZERO;
            tbll_q <= `CSR_RST_ZERO; table_read_latch_q <= `CSR_RST_ZERO; multiply_result_high_q <= `CSR_RST_ZERO;
            multiply_result_low_q <= `CSR_RST_ZERO; irq1_q <= `CSR_RST_ZERO; irq2_q <= `CSR_RST_IRQ2;
            irq3_q <= `CSR_RST_IRQ3; working_accumulator_q <= `CSR_RST_ZERO; ser_ctl2_q <= `CSR_RST_ZERO;
            imask_q <= `CSR_RST_ZERO;
        end
        else if (wr)
        begin
            case (off)
                `CSR_OFF_STACK_TOP_UPPER:     stack_top_upper_q   <= wb & `CSR_MASK_TOS_U;
                `CSR_OFF_STACK_TOP_HIGH:     stack_top_high_q   <= wb;
                `CSR_OFF_STACK_TOP_LOW:     stack_top_low_q   <= wb;
                `CSR_OFF_STK:      stk_q    <= wb & `CSR_MASK_STK;
                // bit 21 only in programming mode
                `CSR_OFF_PC_LATCH_UPPER:   pc_latch_upper_q <= wb & (serial_prog_i ? 8'h3f : 8'h1f);
                `CSR_OFF_PC_LATCH_HIGH:   pc_latch_high_q <= wb;
                `CSR_OFF_PCL:      pcl_q    <= wb;
                `CSR_OFF_TBLU:     tblu_q   <= wb & `CSR_MASK_TBL_U;
                `CSR_OFF_TBLH:     tblh_q   <= wb;
                `CSR_OFF_TBLL:     tbll_q   <= wb;
                `CSR_OFF_TABLE_READ_LATCH:   table_read_latch_q <= wb;
                `CSR_OFF_MULTIPLY_RESULT_HIGH:    multiply_result_high_q  <= wb;
                `CSR_OFF_MULTIPLY_RESULT_LOW:    multiply_result_low_q  <= wb;
                `CSR_OFF_IRQ1:     irq1_q   <= wb;
                `CSR_OFF_IRQ2:     irq2_q   <= wb;
                `CSR_OFF_IRQ3:     irq3_q   <= wb;
                `CSR_OFF_WORKING_ACCUMULATOR:     working_accumulator_q   <= wb;
                // bits keep storage, meaning follows mode
                `CSR_OFF_SER_CTL2: ser_ctl2_q <= wb;
                `CSR_OFF_IRQ_MASK: imask_q  <= wb & {5'h00, `CSR_MASK_IRQ_EV};
                default: ;
            endcase
        end
    end

    // Serial address and mask behind one offset
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ser_addr_q <= `CSR_RST_SER_ADDR;
            ser_mask_q <= `CSR_RST_SER_MASK;
        end
        else if (wr && off == `CSR_OFF_SER_ADDR)
        begin
            if (ser_ctl2_q[3:0] == `CSR_SER_MASK_CODE)
                ser_mask_q <= wb;
            else
                ser_addr_q <= wb;
        end
    end

    // Parallel port shared pair, one storage for both functions
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            par_h_q <= `CSR_RST_ZERO;
            par_l_q <= `CSR_RST_ZERO;
            par_addr_high_o <= `CSR_RST_ZERO;
            par_addr_low_o  <= `CSR_RST_ZERO;
        end
        else
        begin
            // one pair, one address for both
            if (wr && off == `CSR_OFF_PAR_HIGH && pkg_s_q[1])
                par_h_q <= wb;
            if (wr && off == `CSR_OFF_PAR_LOW && pkg_s_q[1])
                par_l_q <= wb;
            // drives address pins only in master modes
            par_addr_high_o <= par_master_i ? par_h_q : `CSR_RST_ZERO;
            par_addr_low_o  <= par_master_i ? par_l_q : `CSR_RST_ZERO;
        end
    end

    // Port A direction and oscillator status
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            dir_q      <= `CSR_RST_DIR;
            osc_startup_status_q     <= 1'b0;
            rst_seen_q <= 1'b0;
        end
        else
        begin
            rst_seen_q <= 1'b1;
            // start-up status from strap after release
            if (!rst_seen_q)
                osc_startup_status_q <= !two_s_q[1];
            else if (two_s_q[1])
                osc_startup_status_q <= 1'b1;
            if (wr && off == `CSR_OFF_PORTA_DIR)
                dir_q <= wb;
        end
    end

    // Sticky event bits, set wins over read clear
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ist_q <= `CSR_RST_ZERO;
            irq_o <= 1'b0;
        end
        else
        begin
            ist_q <= ((rd && off == `CSR_OFF_IRQ_STAT) ? 8'h00 : ist_q) | {5'h00, event_i};
            irq_o <= |(ist_q & imask_q);
        end
    end

    // Read mux
    always_comb
    begin
        mapped = 1'b1;
        rbyte  = 8'h00;
        case (off)
            `CSR_OFF_STACK_TOP_UPPER:   rbyte = stack_top_upper_q;
            `CSR_OFF_STACK_TOP_HIGH:   rbyte = stack_top_high_q;
            `CSR_OFF_STACK_TOP_LOW:   rbyte = stack_top_low_q;
            `CSR_OFF_STK:    rbyte = stk_q;
            // hide bit 21 outside programming mode
            `CSR_OFF_PC_LATCH_UPPER: rbyte = pc_latch_upper_q & (serial_prog_i ? 8'h3f : 8'h1f);
            `CSR_OFF_PC_LATCH_HIGH: rbyte = pc_latch_high_q;
            `CSR_OFF_PCL:    rbyte = pcl_q;
            `CSR_OFF_TBLU:   rbyte = tblu_q;
            `CSR_OFF_TBLH:   rbyte = tblh_q;
            `CSR_OFF_TBLL:   rbyte = tbll_q;
            `CSR_OFF_TABLE_READ_LATCH: rbyte = table_read_latch_q;
            `CSR_OFF_MULTIPLY_RESULT_HIGH:  rbyte = multiply_result_high_q;
            `CSR_OFF_MULTIPLY_RESULT_LOW:  rbyte = multiply_result_low_q;
            `CSR_OFF_IRQ1:   rbyte = irq1_q;
            `CSR_OFF_IRQ2:   rbyte = irq2_q;
            `CSR_OFF_IRQ3:   rbyte = irq3_q;
            `CSR_OFF_PTR0H:  rbyte = {4'h0, ptr0_q[11:8]};
            `CSR_OFF_PTR0L:  rbyte = ptr0_q[7:0];
            `CSR_OFF_WORKING_ACCUMULATOR:   rbyte = working_accumulator_q;
            `CSR_OFF_PTR1H:  rbyte = {4'h0, ptr1_q[11:8]};
            `CSR_OFF_PTR1L:  rbyte = ptr1_q[7:0];
            `CSR_OFF_IND_PLAIN, `CSR_OFF_IND_POSTINC, `CSR_OFF_IND_POSTDEC,
            `CSR_OFF_IND_PREINC, `CSR_OFF_IND_OFFSET: rbyte = dmem_rdata_i;
            `CSR_OFF_SER_ADDR:
                rbyte = (ser_ctl2_q[3:0] == `CSR_SER_MASK_CODE) ? ser_mask_q : ser_addr_q;
            `CSR_OFF_SER_CTL2: rbyte = ser_ctl2_q;
            `CSR_OFF_PAR_HIGH: rbyte = pkg_s_q[1] ? par_h_q : 8'h00;
            `CSR_OFF_PAR_LOW:  rbyte = pkg_s_q[1] ? par_l_q : 8'h00;
            `CSR_OFF_PAR_MODE: rbyte = {6'h00, ser_twowire_slave_i, par_master_i};
            // bits 6 and 7 absent under oscillator use
            `CSR_OFF_PORTA_DIR: rbyte = osc_s_q[1] ? (dir_q & 8'h3f) : dir_q;
            `CSR_OFF_OSC_STAT: rbyte = {4'h0, osc_startup_status_q, 3'h0};
            `CSR_OFF_IRQ_STAT: rbyte = ist_q;
            `CSR_OFF_IRQ_MASK: rbyte = imask_q;
            default: mapped = 1'b0;
        endcase
    end

    // Registered read data and error answer
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else
        begin
            prdata_o  <= {24'h000000, rbyte};
            pslverr_o <= (setup || state_q == csr_pkg::CSR_ST_MEM) && !mapped;
        end
    end

    AST_MASK_SEL: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr && off == `CSR_OFF_SER_ADDR && ser_ctl2_q[3:0] == `CSR_SER_MASK_CODE)
        |=> ser_mask_q == $past(wb))
        else $error("mask not written at code 1001");
    AST_ADDR_SEL: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr && off == `CSR_OFF_SER_ADDR && ser_ctl2_q[3:0] != `CSR_SER_MASK_CODE)
        |=> ser_addr_q == $past(wb) && $stable(ser_mask_q))
        else $error("serial address write wrong target");
    AST_POSTDEC: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rd && off == `CSR_OFF_IND_POSTDEC) |=> ptr1_q == $past(ptr1_q) - 12'h001)
        else $error("post-decrement wrong");
    AST_PREINC_ADDR: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_q == csr_pkg::CSR_ST_IDLE && setup && off == `CSR_OFF_IND_PREINC)
        |=> dmem_o.addr == $past(ptr1_q) + 12'h001)
        else $error("pre-increment address wrong");
    AST_PLAIN_KEEP: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ((wr || rd) && off == `CSR_OFF_IND_PLAIN) |=> $stable(ptr0_q))
        else $error("plain access moved pointer");
    AST_IND_READ: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_q == csr_pkg::CSR_ST_IDLE && setup && ind_hit) |=> dmem_o.req ##1 pready_o)
        else $error("indirect access missed memory");
    AST_PAR_ONE: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr && off == `CSR_OFF_PAR_HIGH && pkg_s_q[1]) |=> par_h_q == $past(wb))
        else $error("parallel pair not written");
    AST_B21: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (!serial_prog_i && rd && off == `CSR_OFF_PC_LATCH_UPPER) |-> rbyte[`CSR_PC_LATCH_UPPER_B21] == 1'b0)
        else $error("bit 21 visible");
    AST_DIR67: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (osc_s_q[1] && off == `CSR_OFF_PORTA_DIR) |-> rbyte[7:6] == 2'b00)
        else $error("direction bits under oscillator");
endmodule : csr_core_regs

// file: core_special_register_file_tb.sv
/*
 Self-checking bench of the core special register file, driven over APB.
 Assumes csr_defines.svh offsets and a data memory that answers with the address pattern.
*/
`timescale 1ns/100ps
`include "csr_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module core_special_register_file_tb;
    logic                   clock_i;
    logic                   rstn_i;
    logic                   psel, penable, pwrite, pready, pslverr, err, irq;
    logic                   par_master, ser_slave, ser_prog, two_speed, osc_porta, large_pkg;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rdata;
    logic [2:0]             event_in;
    logic [7:0]             dmem_rdata, par_hi, par_lo;
    csr_pkg::csr_dmem_req_t dmem, last_req;
    int                     failures, comparisons;

    csr_core_regs i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .dmem_o(dmem), .dmem_rdata_i(dmem_rdata), .par_master_i(par_master),
        .ser_twowire_slave_i(ser_slave), .serial_prog_i(ser_prog), .two_speed_i(two_speed),
        .osc_on_porta_i(osc_porta), .large_pkg_i(large_pkg), .event_i(event_in), .irq_o(irq),
        .par_addr_high_o(par_hi), .par_addr_low_o(par_lo));

    // Clock at 40 MHz
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Data memory: answers with a pattern of the registered address, valid in the same cycle as req
    assign dmem_rdata = dmem.addr[7:0] ^ 8'ha5;

    // Records the last request at the edge that sees it
    always @(posedge clock_i)
    begin
        if (dmem.req)
            last_req <= dmem;
    end

    // Prints counts and verdict, ends the run
    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clock_i);
            n++;
        end
        if (pready !== 1'b1)
        begin
            failures++;
            close_out();
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask : rd

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {par_master, ser_slave, ser_prog, two_speed, osc_porta} = '0;
        large_pkg = 1'b1;
        event_in = 3'h0;
        failures = 0;
        comparisons = 0;
        rstn_i = 1'b0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(`CSR_OFF_STACK_TOP_LOW, 32'h0);
        rd(`CSR_OFF_IRQ2, 32'hff);
        rd(`CSR_OFF_IRQ3, 32'hc0);
        apb(1'b0, `CSR_OFF_OSC_STAT, 32'h0);
        `CHK(rdata[`CSR_OSC_STARTUP_STATUS_BIT], 1'b1)
        $display("test reset values done");
        wr(`CSR_OFF_PC_LATCH_UPPER, 32'hff);
        rd(`CSR_OFF_PC_LATCH_UPPER, 32'h1f);
        ser_prog <= 1'b1;
        wr(`CSR_OFF_PC_LATCH_UPPER, 32'hff);
        rd(`CSR_OFF_PC_LATCH_UPPER, 32'h3f);
        $display("test pc latch done");
        wr(`CSR_OFF_SER_CTL2, 32'h09);
        rd(`CSR_OFF_SER_ADDR, 32'hff);
        wr(`CSR_OFF_SER_ADDR, 32'h5a);
        wr(`CSR_OFF_SER_CTL2, 32'h08);
        rd(`CSR_OFF_SER_ADDR, 32'h00);
        wr(`CSR_OFF_SER_ADDR, 32'h33);
        wr(`CSR_OFF_SER_CTL2, 32'h19);
        rd(`CSR_OFF_SER_ADDR, 32'h5a);
        $display("test serial address share done");
        par_master <= 1'b1;
        wr(`CSR_OFF_PAR_HIGH, 32'h12);
        wr(`CSR_OFF_PAR_LOW, 32'h34);
        repeat (3) @(posedge clock_i);
        `CHK({par_hi, par_lo}, 16'h1234)
        par_master <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK({par_hi, par_lo}, 16'h0000)
        rd(`CSR_OFF_PAR_HIGH, 32'h12);
        rd(`CSR_OFF_PAR_LOW, 32'h34);
        large_pkg <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(`CSR_OFF_PAR_HIGH, 32'h00);
        $display("test parallel pair done");
        wr(`CSR_OFF_PTR0L, 32'h10);
        wr(`CSR_OFF_PTR1L, 32'h20);
        wr(`CSR_OFF_WORKING_ACCUMULATOR, 32'h03);
        wr(`CSR_OFF_IND_PLAIN, 32'h77);
        `CHK(last_req, {1'b1, 1'b1, 12'h010, 8'h77})
        rd(`CSR_OFF_PTR0L, 32'h10);
        rd(`CSR_OFF_IND_POSTINC, 32'hb5);
        `CHK(last_req.addr, 12'h010)
        rd(`CSR_OFF_PTR0L, 32'h11);
        rd(`CSR_OFF_IND_OFFSET, 32'hb1);
        `CHK(last_req.addr, 12'h014)
        rd(`CSR_OFF_PTR0L, 32'h11);
        rd(`CSR_OFF_IND_POSTDEC, 32'h85);
        `CHK(last_req.addr, 12'h020)
        rd(`CSR_OFF_PTR1L, 32'h1f);
        rd(`CSR_OFF_IND_PREINC, 32'h85);
        `CHK(last_req.addr, 12'h020)
        rd(`CSR_OFF_PTR1L, 32'h20);
        rd(`CSR_OFF_IND_PLAIN, 32'hb4);
        rd(`CSR_OFF_PTR0L, 32'h11);
        $display("test indirect access done");
        // Port A direction under oscillator use, serial slave mode readback
        rd(`CSR_OFF_PORTA_DIR, 32'hff);
        osc_porta <= 1'b1;
        ser_slave <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(`CSR_OFF_PORTA_DIR, 32'h3f);
        rd(`CSR_OFF_PAR_MODE, 32'h02);
        $display("test mode dependent bits done");
        // Interrupt: raise masked, unmask, clear by read
        event_in <= 3'h2;
        repeat (2) @(posedge clock_i);
        event_in <= 3'h0;
        repeat (2) @(posedge clock_i);
        `CHK(irq, 1'b0)
        wr(`CSR_OFF_IRQ_MASK, 32'h02);
        repeat (2) @(posedge clock_i);
        `CHK(irq, 1'b1)
        rd(`CSR_OFF_IRQ_STAT, 32'h02);
        repeat (2) @(posedge clock_i);
        `CHK(irq, 1'b0)
        rd(`CSR_OFF_IRQ_STAT, 32'h00);
        $display("test interrupt done");
        // Unmapped offset is refused
        wr(12'h0fc, 32'hff);
        `CHK(err, 1'b1)
        rd(12'h0fc, 32'h0);
        `CHK(err, 1'b1)
        $display("test unmapped done");
        // Second reset with two-speed start-up enabled
        two_speed <= 1'b1;
        rstn_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(`CSR_OFF_OSC_STAT, 32'h0);
        rd(`CSR_OFF_PC_LATCH_UPPER, 32'h0);
        $display("test second reset done");
        close_out();
    end
endmodule : core_special_register_file_tb
